// file: bench/chipset_model.sv
/*
  Chipset-side model that drives the stop-clock and sleep request pins.
  Assumes the bench commands it through the two want inputs and that its
  reset is the power-on reset, so a hard reset leaves the pins alone.
*/
`timescale 1ns/1ps
module chipset_model (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic stop_want_i,
  input wire logic sleep_want_i,
  input wire stop_clock_pkg::special_cycle_t special_cycle_i,
  output logic stop_clock_request_n_o,
  output logic sleep_request_n_o
);
  logic [6:0] wait_r; // Clocks since the stop grant cycle
  // Count from the stop grant cycle, saturating
  always @(posedge ref_clk_i) begin
    if (!rstn_i || !stop_want_i) begin
      wait_r <= 7'h00;
    end else if (special_cycle_i.valid && special_cycle_i.byte_enables_n == 8'hfb) begin
      wait_r <= 7'h01;
    end else if (wait_r != 7'h00 && wait_r != 7'h65) begin
      wait_r <= wait_r + 7'h01;
    end
  end
  // Pins move a fixed 1 ns after the edge
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      stop_clock_request_n_o <= #1 1'b1;
      sleep_request_n_o <= #1 1'b1;
    end else begin
      stop_clock_request_n_o <= #1 ~stop_want_i;
      // Sleep only while stop is held, after the full wait
      sleep_request_n_o <= #1 ~(sleep_want_i && stop_want_i && wait_r == 7'h65);
    end
  end
endmodule

// file: bench/tb_stop_clock_power_state_machine.sv
/*
  Self-checking bench of the stop-clock power state machine.
  Assumes the chipset model drives the stop and sleep pins one clock
  after the bench asks, so latencies compare without the sync delay.
*/
`timescale 1ns/1ps
`include "stop_clock_params.svh"
module tb_stop_clock_power_state_machine;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic pwr_on_rstn_i = 1'b0;
  logic stop_want = 1'b0;
  logic sleep_want = 1'b0;
  logic [4:0] ev = 5'h00; // Events: smi bus_init_n init nmi maskable_irq
  logic flush = 1'b0;
  logic a20 = 1'b0;
  logic ads = 1'b0; // Bus strobe held idle outside snoops
  logic snp = 1'b0;
  logic halt_exec = 1'b0;
  logic smm_ret = 1'b0;
  logic smm_halt = 1'b0;
  logic flush_done = 1'b0;
  logic [31:0] model_specific_register = 32'h0;
  logic stp_n;
  logic slp_n;
  logic [2:0] power_state_o;
  stop_clock_pkg::special_cycle_t special_cycle_o;
  stop_clock_pkg::service_t service_o;
  logic clk_stop_o;
  logic flush_req_o;
  logic addr20_masked_o;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int sc_cnt = 0;
  stop_clock_power_state_machine stop_clock_power_state_machine_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pwr_on_rstn_i(pwr_on_rstn_i),
    .stop_clock_request_n_i(stp_n), .sleep_request_n_i(slp_n),
    .system_mgmt_irq_n_i(~ev[4]), .bus_init_n_i(~ev[3]), .soft_init_n_i(~ev[2]),
    .local_irq_pins_i(ev[1:0]), .flush_request_n_i(~flush), .addr20_mask_n_i(~a20),
    .addr_strobe_n_i(~ads), .snoop_serviced_n_i(~snp), .halt_exec_i(halt_exec),
    .smm_return_i(smm_ret), .smm_to_halt_i(smm_halt), .flush_done_i(flush_done),
    .model_specific_register_i(model_specific_register), .power_state_o(power_state_o),
    .special_cycle_o(special_cycle_o), .service_o(service_o), .clk_stop_o(clk_stop_o),
    .flush_req_o(flush_req_o), .addr20_masked_o(addr20_masked_o));
  chipset_model chipset_model_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(pwr_on_rstn_i), .stop_want_i(stop_want),
    .sleep_want_i(sleep_want), .special_cycle_i(special_cycle_o),
    .stop_clock_request_n_o(stp_n), .sleep_request_n_o(slp_n));
  // Bus clock, 4 ns
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // Compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Clocks until the state code shows, bounded
  task automatic wait_state(input logic [2:0] code, output int n);
    n = 0;
    while (power_state_o !== code && n < 300) begin
      tick(1);
      n++;
    end
    check("state", power_state_o, code);
  endtask
  task automatic test_done;
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Timeout, cycle count and state code range, sampled mid-cycle where settled
  always @(negedge ref_clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      test_done();
    end
    if (special_cycle_o.valid === 1'b1) begin
      sc_cnt++;
    end
    if (pwr_on_rstn_i) begin
      check("range", power_state_o inside {[3'h1:3'h5]}, 1'b1);
    end
  end
  task automatic go_halt;
    int n;
    halt_exec = 1'b1;
    tick(1);
    halt_exec = 1'b0;
    wait_state(`SC_PS_HALT, n);
    check("halt_cyc", special_cycle_o, {1'b1, `SC_BE_HALT, `SC_REQ_SPECIAL});
    tick(1);
    check("cyc_len", special_cycle_o.valid, 1'b0);
  endtask
  // Every wake event leaves halt
  task automatic wake_events;
    int n;
    for (int i = 0; i < 5; i++) begin
      go_halt();
      ev = 5'h01 << i;
      wait_state(`SC_PS_NORMAL, n);
      ev = 5'h00;
      tick(8);
      if (i == 4) begin
        smm_ret = 1'b1;
        tick(1);
        smm_ret = 1'b0;
        tick(1);
        check("smm_norm", power_state_o, `SC_PS_NORMAL);
      end
    end
  endtask
  // Handler return to halt, then flush and mask in halt
  task automatic smm_flush_a20;
    int n;
    go_halt();
    ev = 5'h10;
    wait_state(`SC_PS_NORMAL, n);
    ev = 5'h00;
    tick(6);
    smm_halt = 1'b1;
    smm_ret = 1'b1;
    tick(1);
    smm_ret = 1'b0;
    smm_halt = 1'b0;
    wait_state(`SC_PS_HALT, n);
    flush = 1'b1;
    tick(8);
    check("flush_on", flush_req_o, 1'b1);
    flush = 1'b0;
    tick(6);
    flush_done = 1'b1;
    tick(1);
    flush_done = 1'b0;
    tick(2);
    check("flush_off", flush_req_o, 1'b0);
    check("flush_st", power_state_o, `SC_PS_HALT);
    a20 = 1'b1;
    tick(8);
    check("a20_on", addr20_masked_o, 1'b1);
    a20 = 1'b0;
    tick(8);
    check("a20_off", addr20_masked_o, 1'b0);
    ev = 5'h01;
    wait_state(`SC_PS_NORMAL, n);
    ev = 5'h00;
    tick(8);
  endtask
  // Grant from normal with latched events and an ignored flush
  task automatic stop_normal(input logic en);
    int n;
    int m;
    model_specific_register = {5'h00, en, 26'h0};
    stop_want = 1'b1;
    wait_state(`SC_PS_GRANT, n);
    check("sg_cyc", special_cycle_o, {1'b1, `SC_BE_STOP_GRANT, `SC_REQ_SPECIAL});
    check("clk_stop", clk_stop_o, en);
    ev = 5'h0a;
    flush = 1'b1;
    tick(8);
    check("sg_hold", power_state_o, `SC_PS_GRANT);
    check("no_serv", service_o, 5'h00);
    check("no_flush", flush_req_o, 1'b0);
    ev = 5'h00;
    flush = 1'b0;
    tick(8);
    stop_want = 1'b0;
    wait_state(`SC_PS_NORMAL, m);
    check("exit_lat", 16'(m - n), 16'h9);
    check("serv", service_o, 5'h0a);
    check("clk_run", clk_stop_o, 1'b0);
    tick(8);
  endtask
  // Grant from halt, snoops, and return to halt without a cycle
  task automatic stop_halt;
    int n;
    int s;
    go_halt();
    stop_want = 1'b1;
    wait_state(`SC_PS_GRANT, n);
    check("sg_cyc", special_cycle_o, {1'b1, `SC_BE_STOP_GRANT, `SC_REQ_SPECIAL});
    for (int i = 0; i < 2; i++) begin
      if (i == 1) begin
        s = sc_cnt;
        stop_want = 1'b0;
        wait_state(`SC_PS_HALT, n);
        tick(2);
        check("no_cyc", 16'(sc_cnt - s), 16'h0);
      end
      ads = 1'b1;
      tick(4);
      ads = 1'b0;
      wait_state(`SC_PS_SNOOP, n);
      snp = 1'b1;
      wait_state(i == 0 ? `SC_PS_GRANT : `SC_PS_HALT, n);
      snp = 1'b0;
      tick(8);
    end
    ev = 5'h01;
    wait_state(`SC_PS_NORMAL, n);
    ev = 5'h00;
    tick(8);
  endtask
  // Sleep entry and exit latencies against the grant entry
  task automatic sleep_cycle;
    int e;
    int n;
    model_specific_register = 32'h0400_0000;
    stop_want = 1'b1;
    wait_state(`SC_PS_GRANT, e);
    tick(110);
    sleep_want = 1'b1;
    wait_state(`SC_PS_SLEEP, n);
    check("slp_in", 16'(n - e), 16'h9);
    check("slp_clk", clk_stop_o, 1'b1);
    sleep_want = 1'b0;
    wait_state(`SC_PS_GRANT, n);
    check("slp_out", 16'(n - e), 16'h9);
    stop_want = 1'b0;
    wait_state(`SC_PS_NORMAL, n);
    tick(8);
  endtask
  // Hard reset in grant keeps grant until stop drops
  task automatic reset_grant;
    int n;
    stop_want = 1'b1;
    wait_state(`SC_PS_GRANT, n);
    tick(4);
    rstn_i = 1'b0;
    tick(2);
    rstn_i = 1'b1;
    tick(2);
    check("rst_sg", power_state_o, `SC_PS_GRANT);
    check("rst_cyc", special_cycle_o, {1'b0, `SC_BE_IDLE, `SC_REQ_IDLE});
    stop_want = 1'b0;
    wait_state(`SC_PS_NORMAL, n);
  endtask
  // Main sequence
  initial begin
    tick(12);
    rstn_i = 1'b1;
    pwr_on_rstn_i = 1'b1;
    tick(4);
    check("por_st", power_state_o, `SC_PS_NORMAL);
    check("por_cyc", special_cycle_o, {1'b0, `SC_BE_IDLE, `SC_REQ_IDLE});
    check("por_clk", clk_stop_o, 1'b0);
    wake_events();
    smm_flush_a20();
    stop_normal(1'b1);
    stop_normal(1'b0);
    stop_halt();
    sleep_cycle();
    reset_grant();
    test_done();
  end
endmodule

// file: logic/pin_sync.sv
/*
  Three-stage pin synchroniser with agreement filter, one lane per bit.
  Assumes inputs are asynchronous levels; the filtered output only moves
  when the second and third stages agree.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 11
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : lane
      logic s1_r; // First stage, read only by s2_r
      logic s2_r; // Second stage
      logic s3_r; // Third stage
      logic lvl_r; // Filtered level

      // Shift chain
      always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= async_i[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end

      // Accept a change only once two stages agree
      always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
          lvl_r <= 1'b0;
        end else if (s2_r == s3_r) begin
          lvl_r <= s3_r;
        end
      end

      assign level_o[g] = lvl_r;
    end
  endgenerate

endmodule

// file: logic/stop_clock_params.svh
/*
  Constants of the stop-clock power state machine: state codes, bus cycle
  encodings, latency counts and the clock-stop enable bit position.
  Assumes it is included by bare name wherever these macros are used.
*/
`ifndef STOP_CLOCK_PARAMS_SVH
`define STOP_CLOCK_PARAMS_SVH

// Power state codes as reported on the state output
`define SC_PS_NORMAL 3'h1
`define SC_PS_HALT 3'h2
`define SC_PS_GRANT 3'h3
`define SC_PS_SNOOP 3'h4
`define SC_PS_SLEEP 3'h5

// Latencies in bus clocks
`define SC_GRANT_EXIT_CLKS 4'ha
`define SC_SLEEP_ENTRY_CLKS 4'ha
`define SC_SLEEP_EXIT_CLKS 4'ha

// Special cycle encodings on byte enables and request lines
`define SC_BE_IDLE 8'hff
`define SC_BE_HALT 8'hfd
`define SC_BE_STOP_GRANT 8'hfb
`define SC_REQ_IDLE 5'h00
`define SC_REQ_SPECIAL 5'h08

// Model specific register holding the clock-stop enable, and its bit
`define SC_MSR_POWER_IDX 12'h02a
`define SC_MSR_CLKSTOP_BIT 26

`endif

// file: logic/stop_clock_pkg.sv
/*
  Types of the stop-clock power state machine: state enum and the packed
  carriers for synchronised pins, special bus cycles and serviced events.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package stop_clock_pkg;

  // One-hot power states; there is deliberately no deep sleep state
  typedef enum logic [4:0] {
    ST_NORMAL = 5'b00001,
    ST_HALT = 5'b00010,
    ST_GRANT = 5'b00100,
    ST_SNOOP = 5'b01000,
    ST_SLEEP = 5'b10000
  } pwr_state_t;

  // Synchronised pin levels, all active high
  typedef struct packed {
    logic stp;
    logic slp;
    logic smi;
    logic bus_init_n;
    logic init;
    logic nmi;
    logic maskable_irq;
    logic flush;
    logic a20;
    logic ads;
    logic snpdone;
  } pin_in_t;

  // Special bus cycle presented to the bus unit
  typedef struct packed {
    logic valid;
    logic [7:0] byte_enables_n;
    logic [4:0] req;
  } special_cycle_t;

  // Events handed to the core for service
  typedef struct packed {
    logic smi;
    logic bus_init_n;
    logic init;
    logic nmi;
    logic maskable_irq;
  } service_t;

endpackage

// file: logic/stop_clock_power_state_machine.sv
/*
  Stop-clock power state machine: normal, auto halt, stop grant,
  halt/grant snoop and sleep, with special bus cycles on auto halt and stop grant entry.
  Assumes pins arrive asynchronously, core strobes are on ref_clk_i,
  and the bus unit consumes one-cycle special cycle requests.
*/
// Summary of operation
// - Stop internal clocks only when enable bit set
// - No deep sleep; sleep is lowest state
// - Halt enters auto halt, issues halt cycle
// - Wake events return halt to normal
// - Management interrupt handler returns to normal/halt
// - Flush in halt serviced, stays in halt
// - Address bit 20 mask honoured in halt
// - Stop request in halt enters grant, cycle
// - Grant back to halt without new cycle
// - Stop request in normal enters grant, cycle
// - Leave grant 10 clocks after request drops
// - Bus init in grant latched, serviced later
// - Flush ignored during stop grant
// - Hard reset in grant keeps grant state
// - Address strobe snoop enters snoop, then returns
// - Sleep request moves grant to sleep, back
// - Other interrupts latched in grant, serviced later
// - Sleep reached 10 clocks after request
// - Sleep left 10 clocks after request drops
`timescale 1ns/1ps
`include "stop_clock_params.svh"
module stop_clock_power_state_machine (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic pwr_on_rstn_i,
  input wire logic stop_clock_request_n_i,
  input wire logic sleep_request_n_i,
  input wire logic system_mgmt_irq_n_i,
  input wire logic bus_init_n_i,
  input wire logic soft_init_n_i,
  input wire logic [1:0] local_irq_pins_i,
  input wire logic flush_request_n_i,
  input wire logic addr20_mask_n_i,
  input wire logic addr_strobe_n_i,
  input wire logic snoop_serviced_n_i,
  input wire logic halt_exec_i,
  input wire logic smm_return_i,
  input wire logic smm_to_halt_i,
  input wire logic flush_done_i,
  input wire logic [31:0] model_specific_register_i,
  output logic [2:0] power_state_o,
  output stop_clock_pkg::special_cycle_t special_cycle_o,
  output stop_clock_pkg::service_t service_o,
  output logic clk_stop_o,
  output logic flush_req_o,
  output logic addr20_masked_o
);

  logic [10:0] raw_pins; // Pins, active-low ones inverted, all active high
  logic [10:0] sync_pins; // Filtered pin levels
  stop_clock_pkg::pin_in_t pin; // Named view of the pins
  stop_clock_pkg::pwr_state_t st_r; // Current state
  stop_clock_pkg::pwr_state_t st_nxt; // Next state
  logic [3:0] cnt_r; // Latency counter
  logic [3:0] cnt_nxt; // Next counter value
  logic from_halt_r; // Grant was entered from auto halt
  logic ret_grant_r; // Snoop returns to grant, else to halt
  logic ads_prev_r; // Previous address strobe level
  logic ads_rise; // Snoop phase start
  logic smm_active_r; // Handler running after a halt wake
  logic issue_halt; // Halt cycle request
  logic issue_grant; // Stop grant cycle request
  stop_clock_pkg::service_t cur_evt; // Events present this cycle
  stop_clock_pkg::service_t pending_r; // Events held during grant
  stop_clock_pkg::service_t service_r; // Events released to the core
  stop_clock_pkg::special_cycle_t cycle_r; // Special cycle register
  logic [2:0] power_state_r; // Encoded state
  logic clk_stop_r; // Internal clock stop
  logic flush_req_r; // Flush in progress
  logic a20_r; // Address bit 20 mask
  logic grant_side; // In grant or snooping out of grant

  // Active-low pins inverted to active high before synchronising
  assign raw_pins = {~stop_clock_request_n_i, ~sleep_request_n_i, ~system_mgmt_irq_n_i,
                     ~bus_init_n_i, ~soft_init_n_i, local_irq_pins_i[1], local_irq_pins_i[0],
                     ~flush_request_n_i, ~addr20_mask_n_i, ~addr_strobe_n_i,
                     ~snoop_serviced_n_i};

  // Synchroniser, cleared only at power-on so warm reset sees live pins
  pin_sync #(
    .WIDTH(11)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rstn_i(pwr_on_rstn_i),
    .async_i(raw_pins),
    .level_o(sync_pins)
  );

  assign pin = stop_clock_pkg::pin_in_t'(sync_pins);
  assign ads_rise = pin.ads & ~ads_prev_r;
  assign cur_evt = '{smi: pin.smi, bus_init_n: pin.bus_init_n, init: pin.init,
                     nmi: pin.nmi, maskable_irq: pin.maskable_irq};
  assign grant_side = (st_r == stop_clock_pkg::ST_GRANT) ||
                      ((st_r == stop_clock_pkg::ST_SNOOP) && ret_grant_r);

  // Strobe edge history
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ads_prev_r <= 1'b0;
    end else begin
      ads_prev_r <= pin.ads;
    end
  end

  // Next state and latency counting
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = 4'h0;
    issue_halt = 1'b0;
    issue_grant = 1'b0;
    unique case (st_r)
      stop_clock_pkg::ST_NORMAL: begin
        if (pin.stp) begin
          st_nxt = stop_clock_pkg::ST_GRANT;
          issue_grant = 1'b1;
        end else if (halt_exec_i) begin
          st_nxt = stop_clock_pkg::ST_HALT;
          issue_halt = 1'b1;
        end else if (smm_active_r && smm_return_i && smm_to_halt_i) begin
          st_nxt = stop_clock_pkg::ST_HALT;
        end
      end
      stop_clock_pkg::ST_HALT: begin
        if ((|cur_evt) || (|pending_r)) begin
          st_nxt = stop_clock_pkg::ST_NORMAL;
        end else if (pin.stp) begin
          st_nxt = stop_clock_pkg::ST_GRANT;
          issue_grant = 1'b1;
        end else if (ads_rise) begin
          st_nxt = stop_clock_pkg::ST_SNOOP;
        end
      end
      stop_clock_pkg::ST_GRANT: begin
        if (ads_rise) begin
          st_nxt = stop_clock_pkg::ST_SNOOP;
        end else if (!pin.stp) begin
          // Exit counts ten clocks of a dropped request
          if (cnt_r == `SC_GRANT_EXIT_CLKS - 4'h1) begin
            // Back to halt without a halt cycle
            st_nxt = from_halt_r ? stop_clock_pkg::ST_HALT : stop_clock_pkg::ST_NORMAL;
          end else begin
            cnt_nxt = cnt_r + 4'h1;
          end
        end else if (pin.slp) begin
          if (cnt_r == `SC_SLEEP_ENTRY_CLKS - 4'h1) begin
            st_nxt = stop_clock_pkg::ST_SLEEP;
          end else begin
            cnt_nxt = cnt_r + 4'h1;
          end
        end
      end
      stop_clock_pkg::ST_SNOOP: begin
        if (pin.snpdone) begin
          st_nxt = ret_grant_r ? stop_clock_pkg::ST_GRANT : stop_clock_pkg::ST_HALT;
        end
      end
      stop_clock_pkg::ST_SLEEP: begin
        // Lowest state; only the sleep request leads out
        if (!pin.slp) begin
          if (cnt_r == `SC_SLEEP_EXIT_CLKS - 4'h1) begin
            st_nxt = stop_clock_pkg::ST_GRANT;
          end else begin
            cnt_nxt = cnt_r + 4'h1;
          end
        end
      end
      default: begin
        st_nxt = stop_clock_pkg::ST_NORMAL;
      end
    endcase
  end

  // State register; warm reset inside grant stays in grant
  always_ff @(posedge ref_clk_i) begin
    if (!pwr_on_rstn_i) begin
      st_r <= stop_clock_pkg::ST_NORMAL;
    end else if (!rstn_i) begin
      st_r <= (grant_side || st_r == stop_clock_pkg::ST_SLEEP) ?
              stop_clock_pkg::ST_GRANT : stop_clock_pkg::ST_NORMAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Latency counter
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Where grant and snoop return to
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      from_halt_r <= 1'b0; // After reset grant exits to normal
      ret_grant_r <= 1'b0;
    end else begin
      if (issue_grant) begin
        from_halt_r <= (st_r == stop_clock_pkg::ST_HALT);
      end
      if (st_r != stop_clock_pkg::ST_SNOOP && st_nxt == stop_clock_pkg::ST_SNOOP) begin
        ret_grant_r <= (st_r == stop_clock_pkg::ST_GRANT);
      end
    end
  end

  // Event latching in grant and release on return to normal
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pending_r <= '0;
      service_r <= '0;
    end else begin
      service_r <= '0;
      if (st_r != stop_clock_pkg::ST_NORMAL && st_nxt == stop_clock_pkg::ST_NORMAL) begin
        // Current events merge in so nothing is lost on the clear
        service_r <= pending_r | cur_evt;
        pending_r <= '0;
      end else if (grant_side) begin
        pending_r <= pending_r | cur_evt;
      end
    end
  end

  // Handler in progress after a wake from halt
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      smm_active_r <= 1'b0;
    end else if (st_r == stop_clock_pkg::ST_HALT && st_nxt == stop_clock_pkg::ST_NORMAL &&
                 pin.smi) begin
      smm_active_r <= 1'b1;
    end else if (smm_return_i) begin
      smm_active_r <= 1'b0;
    end
  end

  // Special cycle on halt or grant entry
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cycle_r <= '{valid: 1'b0, byte_enables_n: `SC_BE_IDLE, req: `SC_REQ_IDLE};
    end else if (issue_halt) begin
      cycle_r <= '{valid: 1'b1, byte_enables_n: `SC_BE_HALT, req: `SC_REQ_SPECIAL};
    end else if (issue_grant) begin
      cycle_r <= '{valid: 1'b1, byte_enables_n: `SC_BE_STOP_GRANT,
                   req: `SC_REQ_SPECIAL};
    end else begin
      cycle_r <= '{valid: 1'b0, byte_enables_n: `SC_BE_IDLE, req: `SC_REQ_IDLE};
    end
  end

  // Encoded state, follows the next state so it lines up with st_r
  always_ff @(posedge ref_clk_i) begin
    if (!pwr_on_rstn_i) begin
      power_state_r <= `SC_PS_NORMAL;
    end else begin
      unique case (rstn_i ? st_nxt : ((grant_side || st_r == stop_clock_pkg::ST_SLEEP) ?
                   stop_clock_pkg::ST_GRANT : stop_clock_pkg::ST_NORMAL))
        stop_clock_pkg::ST_NORMAL: power_state_r <= `SC_PS_NORMAL;
        stop_clock_pkg::ST_HALT: power_state_r <= `SC_PS_HALT;
        stop_clock_pkg::ST_GRANT: power_state_r <= `SC_PS_GRANT;
        stop_clock_pkg::ST_SNOOP: power_state_r <= `SC_PS_SNOOP;
        stop_clock_pkg::ST_SLEEP: power_state_r <= `SC_PS_SLEEP;
        default: power_state_r <= `SC_PS_NORMAL;
      endcase
    end
  end

  // Clock stop only in grant or sleep with the enable bit set
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      clk_stop_r <= 1'b0;
    end else begin
      clk_stop_r <= model_specific_register_i[`SC_MSR_CLKSTOP_BIT] &&
                    (st_nxt == stop_clock_pkg::ST_GRANT ||
                     st_nxt == stop_clock_pkg::ST_SLEEP);
    end
  end

  // Flush request: taken in halt, never started in grant; a new request beats done
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      flush_req_r <= 1'b0;
    end else if (st_r == stop_clock_pkg::ST_HALT && pin.flush) begin
      flush_req_r <= 1'b1;
    end else if (flush_req_r && flush_done_i) begin
      flush_req_r <= 1'b0;
    end
  end

  // Address bit 20 mask tracked while the core can issue cycles
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      a20_r <= 1'b0;
    end else if (st_r == stop_clock_pkg::ST_NORMAL || st_r == stop_clock_pkg::ST_HALT) begin
      a20_r <= pin.a20;
    end
  end

  assign power_state_o = power_state_r;
  assign special_cycle_o = cycle_r;
  assign service_o = service_r;
  assign clk_stop_o = clk_stop_r;
  assign flush_req_o = flush_req_r;
  assign addr20_masked_o = a20_r;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  logic grant_quiet; // Grant with stop dropped and no snoop
  logic sleep_held; // Grant with stop and sleep held, no snoop
  logic sleep_dropped; // Sleep with the sleep request dropped
  logic [3:0] quiet_run_r; // Earlier cycles in a row of grant_quiet
  logic [3:0] held_run_r; // Earlier cycles in a row of sleep_held
  logic [3:0] drop_run_r; // Earlier cycles in a row of sleep_dropped

  assign grant_quiet = st_r == stop_clock_pkg::ST_GRANT && !pin.stp && !ads_rise;
  assign sleep_held = st_r == stop_clock_pkg::ST_GRANT && pin.stp && pin.slp && !ads_rise;
  assign sleep_dropped = st_r == stop_clock_pkg::ST_SLEEP && !pin.slp;

  // Run lengths stand in for long repetitions; any other cycle restarts a run
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      quiet_run_r <= 4'h0;
      held_run_r <= 4'h0;
      drop_run_r <= 4'h0;
    end else begin
      quiet_run_r <= grant_quiet ? quiet_run_r + 4'h1 : 4'h0;
      held_run_r <= sleep_held ? held_run_r + 4'h1 : 4'h0;
      drop_run_r <= sleep_dropped ? drop_run_r + 4'h1 : 4'h0;
    end
  end

  // Tenth cycle in a row of each condition
  sequence grant_quiet_s;
    grant_quiet && quiet_run_r == 4'h9;
  endsequence
  sequence sleep_wait_s;
    sleep_held && held_run_r == 4'h9;
  endsequence
  sequence sleep_drop_s;
    sleep_dropped && drop_run_r == 4'h9;
  endsequence
  sequence back_to_halt_s;
    st_r == stop_clock_pkg::ST_GRANT ##1 st_r == stop_clock_pkg::ST_HALT;
  endsequence

  grant_entry_a: assert property (st_r == stop_clock_pkg::ST_NORMAL && pin.stp |=>
    st_r == stop_clock_pkg::ST_GRANT && cycle_r.valid &&
    cycle_r.byte_enables_n == `SC_BE_STOP_GRANT) else $error("no grant entry cycle");
  halt_entry_a: assert property (st_r == stop_clock_pkg::ST_NORMAL && !pin.stp &&
    halt_exec_i |=> st_r == stop_clock_pkg::ST_HALT && cycle_r.byte_enables_n == `SC_BE_HALT)
    else $error("no halt entry cycle");
  halt_wake_a: assert property (st_r == stop_clock_pkg::ST_HALT && (|cur_evt) |=>
    st_r == stop_clock_pkg::ST_NORMAL ##0 service_r != '0) else $error("halt wake missed");
  halt_stop_a: assert property (st_r == stop_clock_pkg::ST_HALT && cur_evt == '0 &&
    pending_r == '0 && pin.stp |=> st_r == stop_clock_pkg::ST_GRANT && cycle_r.valid)
    else $error("halt to grant missed");
  no_rehalt_cycle_a: assert property (back_to_halt_s |-> !cycle_r.valid)
    else $error("halt cycle on grant exit");
  grant_exit_a: assert property (grant_quiet_s |=> st_r != stop_clock_pkg::ST_GRANT)
    else $error("grant exit late");
  early_exit_a: assert property (st_r == stop_clock_pkg::ST_GRANT && !pin.stp &&
    cnt_r < 4'h9 |=> st_r == stop_clock_pkg::ST_GRANT || st_r == stop_clock_pkg::ST_SNOOP)
    else $error("grant exit early");
  bus_init_n_latch_a: assert property (grant_side && pin.bus_init_n |=>
    pending_r.bus_init_n || service_r.bus_init_n) else $error("bus init lost");
  flush_ignore_a: assert property (st_r == stop_clock_pkg::ST_GRANT |=>
    !$rose(flush_req_r)) else $error("flush taken in grant");
  snoop_enter_a: assert property ((st_r == stop_clock_pkg::ST_GRANT ||
    (st_r == stop_clock_pkg::ST_HALT && cur_evt == '0 && pending_r == '0 && !pin.stp)) &&
    ads_rise |=> st_r == stop_clock_pkg::ST_SNOOP) else $error("snoop missed");
  sleep_entry_a: assert property (sleep_wait_s |=> st_r == stop_clock_pkg::ST_SLEEP)
    else $error("sleep entry late");
  sleep_exit_a: assert property (sleep_drop_s |=>
    st_r == stop_clock_pkg::ST_GRANT) else $error("sleep exit late");
  clk_stop_a: assert property (clk_stop_r |-> st_r == stop_clock_pkg::ST_GRANT ||
    st_r == stop_clock_pkg::ST_SLEEP) else $error("clock stopped while awake");
  state_code_a: assert property (st_r == stop_clock_pkg::ST_SLEEP |->
    power_state_r == `SC_PS_SLEEP) else $error("bad sleep code");
  reset_grant_a: assert property (@(posedge ref_clk_i) disable iff (!pwr_on_rstn_i)
    !rstn_i && st_r == stop_clock_pkg::ST_GRANT |=> st_r == stop_clock_pkg::ST_GRANT)
    else $error("reset left grant");

endmodule
